// >>> hw/daq_timing_pkg.sv
// Constants and types shared by the acquisition timing control block
`default_nettype none
package daq_timing_pkg;
    localparam int CNT_W = 16;
    localparam int CLK_HZ = 100_000_000;
    localparam int GP0_HZ = 2_000_000;
    localparam int GP0_DIV = CLK_HZ / GP0_HZ;
    localparam int CHAN_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    typedef enum logic [1:0] {GM_LEVEL, GM_EDGE, GM_FREQ, GM_FREE} gp_mode_t;
    typedef enum {ACQ_IDLE, ACQ_WAIT_TRIG, ACQ_WAIT_CONV_RISE, ACQ_RUN, ACQ_PRE, ACQ_PRE_COUNT}
        acq_state_t;
endpackage
`default_nettype wire

// >>> hw/strobe_sync.sv
// Two-stage synchroniser with edge detection for an asynchronous strobe
`default_nettype none
module strobe_sync #(
    // Reset to the pin's idle level, so an idle pin shows no edge after reset
    parameter logic IDLE_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and conditioned outputs
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= IDLE_LEVEL;
            sync_q <= IDLE_LEVEL;
            prev_q <= IDLE_LEVEL;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// >>> hw/gp_counter.sv
// One 16-bit general purpose down counter with gate modes
`default_nettype none
module gp_counter
    import daq_timing_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Synchronised count and gate events
    input wire logic cnt_tick,
    input wire logic cnt_fall,
    input wire logic gate_level,
    input wire logic gate_rise,
    // Control
    input wire daq_timing_pkg::gp_mode_t mode,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // State
    output logic [WIDTH-1:0] count,
    output logic out
);
    logic [WIDTH-1:0] count_q;
    logic armed_q;
    logic out_q;
    logic step;

    // Frequency mode counts falling clock edges, the others count ticks
    assign step = (mode == GM_LEVEL) ? (cnt_tick & gate_level) :
                  (mode == GM_EDGE) ? (cnt_tick & (armed_q | gate_rise)) :
                  (mode == GM_FREQ) ? (cnt_fall & gate_level) :
                  cnt_tick;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            armed_q <= 1'b0;
            out_q <= 1'b0;
        end
        else if (load)
        begin
            count_q <= load_value;
            armed_q <= 1'b0;
            out_q <= 1'b0;
        end
        else
        begin
            if (gate_rise)
                armed_q <= 1'b1;
            if (step)
                count_q <= count_q - 1'b1;
            out_q <= step && (count_q == WIDTH'(1));
        end
    end

    assign count = count_q;
    assign out = out_q;
endmodule
`default_nettype wire

// >>> hw/daq_trigger_timing_control.sv
// Acquisition trigger, interval, scan gate, DAC update and general counter control
`default_nettype none
module daq_trigger_timing_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // External strobes
    input wire logic ext_convert_strobe_n,
    input wire logic ext_acq_trigger,
    input wire logic scan_interval_strobe,
    input wire logic ext_dac_update_n,
    // Acquisition control
    input wire logic acq_start,
    input wire logic acq_stop,
    input wire logic pre_trigger_mode,
    input wire logic ext_conv_sel,
    input wire logic ext_scan_sel,
    input wire logic scan_enable,
    input wire logic [daq_timing_pkg::CNT_W-1:0] sample_interval,
    input wire logic [daq_timing_pkg::CNT_W-1:0] sample_count,
    input wire logic [daq_timing_pkg::CNT_W-1:0] scan_interval,
    input wire logic [daq_timing_pkg::CHAN_W-1:0] scan_channels,
    // Acquisition status
    output logic convert_pulse,
    output logic acq_active,
    output logic acq_done,
    output logic scan_gate_open,
    // DAC update
    input wire logic dac_write_strobe,
    input wire logic [11:0] dac_value,
    input wire logic delayed_update,
    input wire logic update_int_enable,
    input wire logic update_int_clear,
    output logic [11:0] dac_out,
    output logic update_interrupt,
    // General counters
    input wire logic gp_clk_two,
    input wire logic gp_gate_zero,
    input wire logic gp_gate_two,
    input wire daq_timing_pkg::gp_mode_t gp_mode_zero,
    input wire daq_timing_pkg::gp_mode_t gp_mode_two,
    input wire logic gp_load_zero,
    input wire logic gp_load_two,
    input wire logic [daq_timing_pkg::CNT_W-1:0] gp_load_value,
    output logic [daq_timing_pkg::CNT_W-1:0] general_counter_zero,
    output logic [daq_timing_pkg::CNT_W-1:0] general_counter_two,
    output logic gp_out_zero,
    output logic gp_out_two
);
    import daq_timing_pkg::*;

    logic conv_rise, conv_fall;
    logic trig_rise, scan_rise, upd_lvl, upd_rise;
    logic gate0_lvl, gate0_rise, gate2_lvl, gate2_rise;
    logic gclk2_rise, gclk2_fall;

    // Active-low strobes idle high
    strobe_sync #(.IDLE_LEVEL(1'b1)) u_conv (.clk(clk), .rst_n(rst_n),
        .pin(ext_convert_strobe_n), .level(), .rise(conv_rise), .fall(conv_fall));
    strobe_sync u_trig (.clk(clk), .rst_n(rst_n), .pin(ext_acq_trigger),
        .level(), .rise(trig_rise), .fall());
    strobe_sync u_scan (.clk(clk), .rst_n(rst_n), .pin(scan_interval_strobe),
        .level(), .rise(scan_rise), .fall());
    strobe_sync #(.IDLE_LEVEL(1'b1)) u_upd (.clk(clk), .rst_n(rst_n), .pin(ext_dac_update_n),
        .level(upd_lvl), .rise(upd_rise), .fall());
    strobe_sync u_g0 (.clk(clk), .rst_n(rst_n), .pin(gp_gate_zero),
        .level(gate0_lvl), .rise(gate0_rise), .fall());
    strobe_sync u_g2 (.clk(clk), .rst_n(rst_n), .pin(gp_gate_two),
        .level(gate2_lvl), .rise(gate2_rise), .fall());
    strobe_sync u_c2 (.clk(clk), .rst_n(rst_n), .pin(gp_clk_two),
        .level(), .rise(gclk2_rise), .fall(gclk2_fall));

    acq_state_t state_q, state_d;
    logic [CNT_W-1:0] interval_cnt_q;
    logic [CNT_W-1:0] sample_count_counter_q;
    logic [CNT_W-1:0] scan_interval_counter_q;
    logic [CHAN_W-1:0] chan_q;
    logic gate_q, conv_q, done_q, active_q;
    logic int_tick, scan_tick, conv_req, gated_conv, converting, samples_last;

    // Internal pacing reloads when the count reaches one; external falling edge replaces it
    assign int_tick = (interval_cnt_q == CNT_ONE);
    assign conv_req = ext_conv_sel ? conv_fall : int_tick;
    assign scan_tick = ext_scan_sel ? scan_rise
                                    : (scan_interval_counter_q == CNT_ONE);
    assign converting = (state_q == ACQ_RUN) || (state_q == ACQ_PRE)
                        || (state_q == ACQ_PRE_COUNT);
    assign gated_conv = converting && conv_req && (!scan_enable || gate_q);
    assign samples_last = (sample_count_counter_q == CNT_ONE);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ACQ_IDLE:
                if (acq_start)
                    state_d = pre_trigger_mode ? ACQ_PRE : ACQ_WAIT_TRIG;
            ACQ_WAIT_TRIG:
                if (trig_rise)
                    state_d = ext_conv_sel ? ACQ_WAIT_CONV_RISE : ACQ_RUN;
            ACQ_WAIT_CONV_RISE:
                if (conv_rise)
                    state_d = ACQ_RUN;
            ACQ_RUN:
                if (gated_conv && samples_last)
                    state_d = ACQ_IDLE;
            ACQ_PRE:
                if (trig_rise)
                    state_d = ACQ_PRE_COUNT;
            ACQ_PRE_COUNT:
                if (gated_conv && samples_last)
                    state_d = ACQ_IDLE;
            default:
                state_d = ACQ_IDLE;
        endcase
        // A start wins over a software abort; trigger edges outside ACQ_WAIT_TRIG and ACQ_PRE fall through unused
        if (acq_stop)
            state_d = ACQ_IDLE;
        if (acq_start)
            state_d = pre_trigger_mode ? ACQ_PRE : ACQ_WAIT_TRIG;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ACQ_IDLE;
        else
            state_q <= state_d;
    end

    // Sample counter only decrements in run or post-trigger counting phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sample_count_counter_q <= CNT_ZERO;
        else if (acq_start)
            sample_count_counter_q <= sample_count;
        else if (gated_conv && state_q != ACQ_PRE && sample_count_counter_q != CNT_ZERO)
            sample_count_counter_q <= sample_count_counter_q - CNT_ONE;
    end

    // Interval counter held at reload until the sequence runs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            interval_cnt_q <= CNT_ZERO;
        else if (!converting || int_tick)
            interval_cnt_q <= sample_interval;
        else if (interval_cnt_q != CNT_ZERO)
            interval_cnt_q <= interval_cnt_q - CNT_ONE;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            scan_interval_counter_q <= CNT_ZERO;
        else if (!converting || scan_interval_counter_q == CNT_ONE
                 || scan_interval_counter_q == CNT_ZERO)
            scan_interval_counter_q <= scan_interval;
        else
            scan_interval_counter_q <= scan_interval_counter_q - CNT_ONE;
    end

    // Scan gate: armed by scan edge, opened by next convert rise (next cycle under internal pacing), closed after last channel
    logic scan_armed_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_armed_q <= 1'b0;
            gate_q <= 1'b0;
            chan_q <= '0;
        end
        else if (scan_tick)
        begin
            scan_armed_q <= 1'b1;
            gate_q <= 1'b0;
            chan_q <= '0;
        end
        // A new sequence must not inherit a gate left open by the last one
        else if (acq_start)
        begin
            scan_armed_q <= 1'b0;
            gate_q <= 1'b0;
            chan_q <= '0;
        end
        else if (scan_armed_q && (ext_conv_sel ? conv_rise : 1'b1))
        begin
            scan_armed_q <= 1'b0;
            gate_q <= 1'b1;
        end
        else if (gated_conv)
        begin
            chan_q <= chan_q + 1'b1;
            if (chan_q == scan_channels)
                gate_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_q <= 1'b0;
            done_q <= 1'b0;
            active_q <= 1'b0;
        end
        else
        begin
            conv_q <= gated_conv;
            done_q <= converting && (state_d == ACQ_IDLE);
            active_q <= (state_d != ACQ_IDLE);
        end
    end

    // DAC update: delayed mode applies held value while the strobe is low
    logic [11:0] dac_hold_q, dac_out_q;
    logic int_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dac_hold_q <= 12'h000;
            dac_out_q <= 12'h000;
            int_q <= 1'b0;
        end
        else
        begin
            if (dac_write_strobe)
                dac_hold_q <= dac_value;
            if (dac_write_strobe && !delayed_update)
                dac_out_q <= dac_value;
            else if (delayed_update && !upd_lvl)
                dac_out_q <= dac_hold_q;
            // A new edge wins over a clear in the same cycle
            if (update_int_enable && upd_rise)
                int_q <= 1'b1;
            else if (update_int_clear || !update_int_enable)
                int_q <= 1'b0;
        end
    end

    // Counter zero ticks from the internal 2 MHz divider
    logic [CNT_W-1:0] div_q;
    logic tick2m;
    assign tick2m = (div_q == CNT_W'(GP0_DIV - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= CNT_ZERO;
        else if (tick2m)
            div_q <= CNT_ZERO;
        else
            div_q <= div_q + CNT_ONE;
    end

    logic [CNT_W-1:0] c0, c2;
    logic o0, o2;
    gp_counter #(.WIDTH(CNT_W)) u_gp0 (.clk(clk), .rst_n(rst_n), .cnt_tick(tick2m),
        .cnt_fall(tick2m), .gate_level(gate0_lvl), .gate_rise(gate0_rise),
        .mode(gp_mode_zero), .load(gp_load_zero), .load_value(gp_load_value),
        .count(c0), .out(o0));
    gp_counter #(.WIDTH(CNT_W)) u_gp2 (.clk(clk), .rst_n(rst_n), .cnt_tick(gclk2_rise),
        .cnt_fall(gclk2_fall), .gate_level(gate2_lvl), .gate_rise(gate2_rise),
        .mode(gp_mode_two), .load(gp_load_two), .load_value(gp_load_value),
        .count(c2), .out(o2));

    assign convert_pulse = conv_q;
    assign acq_active = active_q;
    assign acq_done = done_q;
    assign scan_gate_open = gate_q;
    assign dac_out = dac_out_q;
    assign update_interrupt = int_q;
    assign general_counter_zero = c0;
    assign general_counter_two = c2;
    assign gp_out_zero = o0;
    assign gp_out_two = o2;

    // Assertions
    property p_trig_ignored;
        @(posedge clk) disable iff (!rst_n)
        (state_q == ACQ_RUN && trig_rise && !acq_start && !acq_stop && !gated_conv)
            |=> (state_q == ACQ_RUN);
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("Trigger acted twice");

    property p_post_start;
        @(posedge clk) disable iff (!rst_n)
        (state_q == ACQ_WAIT_TRIG && trig_rise && !ext_conv_sel && !acq_start && !acq_stop)
            |=> (state_q == ACQ_RUN);
    endproperty
    a_post_start: assert property (p_post_start) else $error("Trigger did not start");

    property p_pre_halt;
        @(posedge clk) disable iff (!rst_n)
        (state_q == ACQ_PRE && !acq_start) |=> $stable(sample_count_counter_q);
    endproperty
    a_pre_halt: assert property (p_pre_halt) else $error("Sample counter moved early");

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
        acq_start |=> (sample_count_counter_q == $past(sample_count));
    endproperty
    a_reload: assert property (p_reload) else $error("Sample count not reloaded");

    property p_conv_out;
        @(posedge clk) disable iff (!rst_n)
        (ext_conv_sel && conv_fall && state_q == ACQ_RUN && !scan_enable) |=> convert_pulse;
    endproperty
    a_conv_out: assert property (p_conv_out) else $error("Missed convert");

    property p_no_conv_gated;
        @(posedge clk) disable iff (!rst_n)
        (scan_enable && !gate_q) |=> !convert_pulse;
    endproperty
    a_no_conv_gated: assert property (p_no_conv_gated) else $error("Convert through closed gate");

    property p_upd_int;
        @(posedge clk) disable iff (!rst_n)
        (update_int_enable && upd_rise) |=> update_interrupt;
    endproperty
    a_upd_int: assert property (p_upd_int) else $error("Update interrupt missed");

    property p_immediate;
        @(posedge clk) disable iff (!rst_n)
        (dac_write_strobe && !delayed_update) |=> (dac_out == $past(dac_value));
    endproperty
    a_immediate: assert property (p_immediate) else $error("Immediate update missed");

    property p_delayed_hold;
        @(posedge clk) disable iff (!rst_n)
        (delayed_update && upd_lvl) |=> $stable(dac_out);
    endproperty
    a_delayed_hold: assert property (p_delayed_hold) else $error("Delayed value leaked");
endmodule
`default_nettype wire

// >>> tb/ext_timing_source.sv
// Model of the external sources driving the convert, trigger, scan, update and counter pins
`default_nettype none
module ext_timing_source (
    // Clock
    input wire logic clk,
    // Strobes toward the block
    output logic convert_n,
    output logic trigger,
    output logic scan,
    output logic update_n,
    output logic gp_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        convert_n = 1'b1;
        trigger = 1'b0;
        scan = 1'b0;
        update_n = 1'b1;
        gp_clk = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Phases span several clocks so the two-flop synchroniser sees each level
    task automatic conv_pulse();
        convert_n = 1'b0;
        hold(5);
        convert_n = 1'b1;
        hold(5);
    endtask
    // The first enabling convert rise follows a trigger rise by at least 50 ns
    task automatic trig_rise();
        trigger = 1'b1;
        hold(6);
    endtask
    task automatic trig_low();
        trigger = 1'b0;
        hold(6);
    endtask
    // The scan rise leads the next convert rise by well over 50 ns
    task automatic scan_pulse();
        scan = 1'b1;
        hold(6);
        scan = 1'b0;
    endtask
    // Low pulse kept short but well over 50 ns
    task automatic update_pulse();
        update_n = 1'b0;
        hold(8);
        update_n = 1'b1;
        hold(8);
    endtask
    task automatic gp_pulse();
        gp_clk = 1'b1;
        hold(4);
        gp_clk = 1'b0;
        hold(4);
    endtask
endmodule
`default_nettype wire

// >>> tb/daq_trigger_timing_control_tb.sv
// Self-checking testbench for the acquisition timing control block
`default_nettype none
module daq_trigger_timing_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import daq_timing_pkg::*;
    logic clk, rst_n, conv_n, trig, scan, upd_n, gp_clk;
    logic acq_start, acq_stop, pre_trigger_mode, ext_conv_sel, ext_scan_sel, scan_enable;
    logic [CNT_W-1:0] sample_interval, sample_count, scan_interval, gp_load_value, gc0, gc2;
    logic [CHAN_W-1:0] scan_channels;
    logic convert_pulse, acq_active, acq_done, scan_gate_open, update_interrupt;
    logic dac_write_strobe, delayed_update, update_int_enable, update_int_clear;
    logic [11:0] dac_value, dac_out;
    logic gp_gate_zero, gp_gate_two, gp_load_zero, gp_load_two, gp_out_zero, gp_out_two;
    gp_mode_t gp_mode_zero, gp_mode_two;
    int n_fail = 0;
    int checked = 0;
    int n_conv = 0;
    int n_done = 0;
    int n_out0 = 0;
    int n_out2 = 0;
    int c0, d0;
    logic [CNT_W-1:0] g0;

    ext_timing_source u_ext_timing_source (.clk(clk), .convert_n(conv_n), .trigger(trig),
        .scan(scan), .update_n(upd_n), .gp_clk(gp_clk));

    daq_trigger_timing_control u_daq_trigger_timing_control (.clk(clk), .rst_n(rst_n),
        .ext_convert_strobe_n(conv_n), .ext_acq_trigger(trig),
        .scan_interval_strobe(scan), .ext_dac_update_n(upd_n), .acq_start(acq_start),
        .acq_stop(acq_stop), .pre_trigger_mode(pre_trigger_mode),
        .ext_conv_sel(ext_conv_sel), .ext_scan_sel(ext_scan_sel), .scan_enable(scan_enable),
        .sample_interval(sample_interval), .sample_count(sample_count),
        .scan_interval(scan_interval), .scan_channels(scan_channels),
        .convert_pulse(convert_pulse), .acq_active(acq_active), .acq_done(acq_done),
        .scan_gate_open(scan_gate_open), .dac_write_strobe(dac_write_strobe),
        .dac_value(dac_value), .delayed_update(delayed_update),
        .update_int_enable(update_int_enable), .update_int_clear(update_int_clear),
        .dac_out(dac_out), .update_interrupt(update_interrupt), .gp_clk_two(gp_clk),
        .gp_gate_zero(gp_gate_zero), .gp_gate_two(gp_gate_two),
        .gp_mode_zero(gp_mode_zero), .gp_mode_two(gp_mode_two),
        .gp_load_zero(gp_load_zero), .gp_load_two(gp_load_two),
        .gp_load_value(gp_load_value), .general_counter_zero(gc0),
        .general_counter_two(gc2), .gp_out_zero(gp_out_zero), .gp_out_two(gp_out_two));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse outputs stand one cycle, so they are counted at every edge
    always @(posedge clk)
    begin
        if (convert_pulse === 1'b1)
            n_conv = n_conv + 1;
        if (acq_done === 1'b1)
            n_done = n_done + 1;
        if (gp_out_zero === 1'b1)
            n_out0 = n_out0 + 1;
        if (gp_out_two === 1'b1)
            n_out2 = n_out2 + 1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic start_acq();
        acq_start = 1'b1;
        step(1);
        acq_start = 1'b0;
        step(3);
        c0 = n_conv;
        d0 = n_done;
    endtask

    task automatic post_internal();
        pre_trigger_mode = 1'b0;
        ext_conv_sel = 1'b0;
        sample_interval = 16'h0004;
        sample_count = 16'h0003;
        start_acq();
        chk("active", 16'h1, {15'h0, acq_active});
        step(20);
        chk("conv before trig", 16'h0, 16'(n_conv - c0));
        u_ext_timing_source.trig_rise();
        step(40);
        chk("conv count", 16'h3, 16'(n_conv - c0));
        chk("done", 16'h1, 16'(n_done - d0));
        chk("active end", 16'h0, {15'h0, acq_active});
        u_ext_timing_source.trig_low();
        u_ext_timing_source.trig_rise();
        step(40);
        chk("retrig", 16'h3, 16'(n_conv - c0));
        u_ext_timing_source.trig_low();
    endtask

    task automatic post_external();
        ext_conv_sel = 1'b1;
        sample_count = 16'h0002;
        start_acq();
        u_ext_timing_source.conv_pulse();
        chk("conv unarmed", 16'h0, 16'(n_conv - c0));
        u_ext_timing_source.trig_rise();
        u_ext_timing_source.conv_pulse();
        // A second trigger in mid-run must not restart the sequence
        u_ext_timing_source.trig_low();
        u_ext_timing_source.trig_rise();
        repeat (3) u_ext_timing_source.conv_pulse();
        step(6);
        chk("ext conv count", 16'h2, 16'(n_conv - c0));
        chk("ext done", 16'h1, 16'(n_done - d0));
        u_ext_timing_source.trig_low();
    endtask

    task automatic pre_trigger();
        pre_trigger_mode = 1'b1;
        sample_count = 16'h0002;
        start_acq();
        repeat (3) u_ext_timing_source.conv_pulse();
        step(6);
        chk("pre conv", 16'h3, 16'(n_conv - c0));
        chk("pre no done", 16'h0, 16'(n_done - d0));
        u_ext_timing_source.trig_rise();
        repeat (4) u_ext_timing_source.conv_pulse();
        step(6);
        chk("post-trig conv", 16'h5, 16'(n_conv - c0));
        chk("pre done", 16'h1, 16'(n_done - d0));
        u_ext_timing_source.trig_low();
        pre_trigger_mode = 1'b0;
    endtask

    task automatic scan_gate();
        ext_conv_sel = 1'b1;
        ext_scan_sel = 1'b1;
        scan_enable = 1'b1;
        pre_trigger_mode = 1'b1;
        scan_channels = 3'h1;
        start_acq();
        u_ext_timing_source.conv_pulse();
        chk("conv gate shut", 16'h0, 16'(n_conv - c0));
        u_ext_timing_source.scan_pulse();
        u_ext_timing_source.conv_pulse();
        chk("gate open", 16'h1, {15'h0, scan_gate_open});
        chk("conv on open", 16'h0, 16'(n_conv - c0));
        repeat (3) u_ext_timing_source.conv_pulse();
        chk("scan conv", 16'h2, 16'(n_conv - c0));
        chk("gate closed", 16'h0, {15'h0, scan_gate_open});
        acq_stop = 1'b1;
        step(1);
        acq_stop = 1'b0;
        step(3);
        chk("stopped", 16'h0, {15'h0, acq_active});
        {ext_scan_sel, scan_enable, pre_trigger_mode} = '0;
    endtask

    task automatic dac_update();
        dac_value = 12'h5a3;
        dac_write_strobe = 1'b1;
        step(1);
        dac_write_strobe = 1'b0;
        step(2);
        chk("dac immediate", 16'h05a3, {4'h0, dac_out});
        delayed_update = 1'b1;
        update_int_enable = 1'b1;
        dac_value = 12'h0c7;
        dac_write_strobe = 1'b1;
        step(1);
        dac_write_strobe = 1'b0;
        step(10);
        chk("dac held", 16'h05a3, {4'h0, dac_out});
        u_ext_timing_source.update_pulse();
        chk("dac delayed", 16'h00c7, {4'h0, dac_out});
        chk("irq set", 16'h1, {15'h0, update_interrupt});
        update_int_clear = 1'b1;
        step(1);
        update_int_clear = 1'b0;
        step(2);
        chk("irq clear", 16'h0, {15'h0, update_interrupt});
        update_int_enable = 1'b0;
        u_ext_timing_source.update_pulse();
        chk("irq masked", 16'h0, {15'h0, update_interrupt});
    endtask

    task automatic counters();
        gp_load_value = 16'h0100;
        gp_mode_two = GM_FREQ;
        gp_mode_zero = GM_EDGE;
        gp_load_two = 1'b1;
        gp_load_zero = 1'b1;
        step(1);
        gp_load_two = 1'b0;
        gp_load_zero = 1'b0;
        gp_gate_two = 1'b1;
        step(4);
        repeat (7) u_ext_timing_source.gp_pulse();
        gp_gate_two = 1'b0;
        step(4);
        chk("freq count", 16'h00f9, gc2);
        repeat (3) u_ext_timing_source.gp_pulse();
        chk("gate low hold", 16'h00f9, gc2);
        step(200);
        chk("edge wait", 16'h0100, gc0);
        gp_gate_zero = 1'b1;
        step(4);
        gp_gate_zero = 1'b0;
        g0 = gc0;
        step(500);
        // 500 clocks at 2 MHz ticks: ten counts, one either way for tick phase
        chk("tick rate", 16'h1, {15'h0, (g0 - gc0) >= 16'd9 && (g0 - gc0) <= 16'd11});
        // Any 100 gated clocks hold exactly two 2 MHz ticks
        gp_mode_zero = GM_LEVEL;
        gp_load_zero = 1'b1;
        step(1);
        gp_load_zero = 1'b0;
        gp_gate_zero = 1'b1;
        step(100);
        gp_gate_zero = 1'b0;
        step(4);
        chk("level gate", 16'h00fe, gc0);
        gp_mode_zero = GM_FREE;
        gp_mode_two = GM_FREE;
        gp_load_value = 16'h0002;
        gp_load_zero = 1'b1;
        gp_load_two = 1'b1;
        step(1);
        gp_load_zero = 1'b0;
        gp_load_two = 1'b0;
        c0 = n_out0;
        d0 = n_out2;
        repeat (15) u_ext_timing_source.gp_pulse();
        chk("out zero", 16'h1, 16'(n_out0 - c0));
        chk("out two", 16'h1, 16'(n_out2 - d0));
    endtask

    initial
    begin
        rst_n = 1'b0;
        {acq_start, acq_stop, pre_trigger_mode, ext_conv_sel, ext_scan_sel} = '0;
        {scan_enable, dac_write_strobe, delayed_update, update_int_enable} = '0;
        {update_int_clear, gp_gate_zero, gp_gate_two, gp_load_zero, gp_load_two} = '0;
        sample_interval = 16'h0004;
        sample_count = 16'h0001;
        scan_interval = 16'h0040;
        scan_channels = 3'h1;
        dac_value = 12'h000;
        gp_load_value = 16'h0000;
        gp_mode_zero = GM_LEVEL;
        gp_mode_two = GM_LEVEL;
        step(6);
        rst_n = 1'b1;
        step(2);
        chk("reset dac", 16'h0, {4'h0, dac_out});
        post_internal();
        post_external();
        pre_trigger();
        scan_gate();
        dac_update();
        counters();
        summarize();
    end

    // Scenarios take under two thousand cycles; this limit leaves wide margin
    initial
    begin
        #500000;
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
